/* File: src/ccn_clock_network_control.sv */
// module: clock control units, quadrant clock buses and register slave
//
// The Avalon-MM register port and the register addresses were left to the implementer.
`timescale 1ns/10ps
module ccn_clock_network_control #(
    parameter logic [ccn_pkg::NUM_PLL-1:0] CORNER_PLL_MASK = '0
) (
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    // register bus
    input wire ccn_pkg::ccn_avm_req_s avm_req_i,
    output logic [ccn_pkg::DATA_W-1:0] avm_readdata_o,
    output logic avm_waitrequest_o,
    // clock sources
    input wire logic [ccn_pkg::NUM_PIN-1:0] clk_pin_i,
    input wire logic [ccn_pkg::NUM_PLL-1:0] pll_counter_output_zero_i,
    input wire logic [ccn_pkg::NUM_PLL-1:0] pll_counter_output_one_i,
    input wire logic [ccn_pkg::NUM_GLB-1:0] glb_fabric_src_i,
    input wire logic [ccn_pkg::NUM_RGN-1:0] rgn_fabric_src_i,
    input wire logic [ccn_pkg::NUM_PPO-1:0] ppo_fabric_src_i,
    input wire logic [ccn_pkg::NUM_RGN-1:0] dual_rgn_neigh_i,
    // fabric control
    input wire logic [2*ccn_pkg::NUM_GLB-1:0] clock_source_select_i,
    input wire logic [ccn_pkg::NUM_GLB-1:0] glb_enable_i,
    input wire logic [ccn_pkg::NUM_RGN-1:0] rgn_enable_i,
    input wire logic [ccn_pkg::NUM_PPO-1:0] ppo_enable_i,
    input wire logic [ccn_pkg::NUM_PPO-1:0] ppo_pin_data_i,
    // clock loads
    output logic [ccn_pkg::NUM_GLB-1:0] global_clock_net_o,
    output logic [ccn_pkg::NUM_RGN-1:0] regional_clock_net_o,
    output logic [ccn_pkg::NUM_RGN-1:0] dual_rgn_out_o,
    output logic [ccn_pkg::NUM_PPO-1:0] pll_out_pin_o,
    output logic [ccn_pkg::NUM_ROW-1:0] row_clock_o,
    output logic [ccn_pkg::NUM_CLU-1:0] logic_cluster_clock_o,
    output logic [ccn_pkg::NUM_IOC-1:0] io_element_clock_o
);
    //==========================================================================
    // state
    ccn_pkg::ccn_state_s st_reg;
    ccn_pkg::ccn_state_s st_next;
    logic [ccn_pkg::NUM_GLB-1:0][ccn_pkg::SEL_W-1:0] glb_choice;
    logic [ccn_pkg::NUM_RGN-1:0][ccn_pkg::SEL_W-1:0] rgn_choice;
    logic [ccn_pkg::NUM_GLB-1:0] glb_src;
    logic [ccn_pkg::NUM_RGN-1:0] rgn_src;
    logic [ccn_pkg::NUM_PPO-1:0] ppo_src;
    logic clu_pick0;

    //==========================================================================
    // selector inputs of one unit, even pin on input 0, odd pin on input 1
    function automatic logic [ccn_pkg::NUM_SRC-1:0] src_vec(
        input int u,
        input logic fab,
        input logic nb
    );
        int pl;
        int pn;
        pl = u % ccn_pkg::NUM_PLL;
        pn = 2 * (u % ccn_pkg::PIN_PAIRS);
        src_vec = {nb, fab, st_reg.c1_s2[pl], st_reg.c0_s2[pl],
                   st_reg.pin_s2[pn+1], st_reg.pin_s2[pn]};
    endfunction : src_vec

    function automatic logic pick(
        input logic [ccn_pkg::NUM_SRC-1:0] vec,
        input logic [ccn_pkg::SEL_W-1:0] sel
    );
        pick = (int'(sel) < ccn_pkg::NUM_SRC) ? vec[sel] : 1'h0;
    endfunction : pick

    //==========================================================================
    // next state
    always_comb begin
        logic [ccn_pkg::NUM_LINE-1:0] lines;
        logic [ccn_pkg::CFG_W-1:0] c;
        logic [ccn_pkg::DSEL_W-1:0] dsel;
        logic [ccn_pkg::LSEL_W-1:0] lsel;
        logic [ccn_pkg::CSEL_W-1:0] csel;
        logic is_pll;
        logic req;
        logic [ccn_pkg::IDX_W-1:0] idx;
        lines = '0;
        c = '0;
        dsel = '0;
        lsel = '0;
        csel = '0;
        is_pll = 1'h0;
        req = 1'h0;
        idx = '0;
        st_next = st_reg;
        glb_choice = '0;
        rgn_choice = '0;
        glb_src = '0;
        rgn_src = '0;
        ppo_src = '0;
        // source synchronisers
        st_next.pin_s1 = clk_pin_i;
        st_next.pin_s2 = st_reg.pin_s1;
        st_next.c0_s1 = pll_counter_output_zero_i;
        st_next.c0_s2 = st_reg.c0_s1;
        st_next.c1_s1 = pll_counter_output_one_i;
        st_next.c1_s2 = st_reg.c1_s1;
        st_next.nb_s1 = dual_rgn_neigh_i;
        st_next.nb_s2 = st_reg.nb_s1;
        // global units
        for (int g = 0; g < ccn_pkg::NUM_GLB; g++) begin
            c = st_reg.cfg[ccn_pkg::CFG_GLB + g];
            dsel = clock_source_select_i[g*ccn_pkg::DSEL_W +: ccn_pkg::DSEL_W];
            glb_choice[g] = c[ccn_pkg::F_SEL +: ccn_pkg::SEL_W];
            if (c[ccn_pkg::F_DYN] &&
                !(dsel[1] && CORNER_PLL_MASK[g % ccn_pkg::NUM_PLL])) begin
                glb_choice[g] = {1'h0, dsel};
            end
            glb_src[g] = pick(src_vec(g, glb_fabric_src_i[g], 1'h0),
                              glb_choice[g]);
            if (!glb_src[g]) begin
                st_next.glb_gate[g] =
                    glb_enable_i[g] & c[ccn_pkg::F_EN];
            end
            st_next.glb_net[g] = glb_src[g] & st_reg.glb_gate[g];
        end
        // regional units
        for (int r = 0; r < ccn_pkg::NUM_RGN; r++) begin
            c = st_reg.cfg[ccn_pkg::CFG_RGN + r];
            rgn_choice[r] = c[ccn_pkg::F_SEL +: ccn_pkg::SEL_W];
            rgn_src[r] = pick(src_vec(r, rgn_fabric_src_i[r],
                                      st_reg.nb_s2[r]), rgn_choice[r]);
            if (!rgn_src[r]) begin
                st_next.rgn_gate[r] =
                    rgn_enable_i[r] & c[ccn_pkg::F_EN];
            end
            st_next.rgn_net[r] = rgn_src[r] & st_reg.rgn_gate[r];
            is_pll = (rgn_choice[r] == ccn_pkg::SRC_PLL_C0) ||
                     (rgn_choice[r] == ccn_pkg::SRC_PLL_C1);
            st_next.dual_out[r] = st_reg.rgn_net[r] & c[ccn_pkg::F_AUX] &
                !(is_pll && CORNER_PLL_MASK[r % ccn_pkg::NUM_PLL]);
        end
        // pll output pin units
        for (int p = 0; p < ccn_pkg::NUM_PPO; p++) begin
            c = st_reg.cfg[ccn_pkg::CFG_PPO + p];
            ppo_src[p] = pick(src_vec(p, ppo_fabric_src_i[p], 1'h0),
                              c[ccn_pkg::F_SEL +: ccn_pkg::SEL_W]);
            if (!ppo_src[p]) begin
                st_next.ppo_gate[p] = ppo_enable_i[p];
            end
            st_next.ppo_pin[p] = c[ccn_pkg::F_AUX] ?
                (ppo_src[p] & st_reg.ppo_gate[p]) :
                ppo_pin_data_i[p];
        end
        // quadrant buses
        lines = {st_reg.rgn_net, st_reg.glb_net};
        for (int i = 0; i < ccn_pkg::NUM_ROW; i++) begin
            lsel = st_reg.cfg[ccn_pkg::CFG_ROW + i][ccn_pkg::LSEL_W-1:0];
            st_next.row[i] = (int'(lsel) < ccn_pkg::NUM_LINE) ?
                lines[lsel] : 1'h0;
        end
        for (int k = 0; k < ccn_pkg::NUM_CLU; k++) begin
            csel = st_reg.cfg[ccn_pkg::CFG_CLU + k][ccn_pkg::CSEL_W-1:0];
            st_next.clu[k] = (int'(csel) < ccn_pkg::NUM_ROW) ?
                st_reg.row[csel] : 1'h0;
        end
        for (int i = 0; i < ccn_pkg::NUM_IOC; i++) begin
            lsel = st_reg.cfg[ccn_pkg::CFG_IOC + i][ccn_pkg::LSEL_W-1:0];
            st_next.ioc[i] = (int'(lsel) < ccn_pkg::NUM_LINE) ?
                lines[lsel] : 1'h0;
        end
        // register slave, one wait state per access
        req = avm_req_i.read | avm_req_i.write;
        idx = avm_req_i.address[ccn_pkg::ADDR_W-1:ccn_pkg::ADDR_LSB];
        st_next.ack = req & !st_reg.ack;
        if (avm_req_i.write && st_reg.ack && avm_req_i.byteenable[0] &&
            int'(idx) < ccn_pkg::NUM_CFG) begin
            st_next.cfg[idx] = avm_req_i.writedata[ccn_pkg::CFG_W-1:0];
        end
        if (avm_req_i.read && !st_reg.ack) begin
            st_next.rdata = '0;
            if (int'(idx) < ccn_pkg::NUM_CFG) begin
                st_next.rdata[ccn_pkg::CFG_W-1:0] = st_reg.cfg[idx];
            end else if (int'(idx) == ccn_pkg::STAT_GLB) begin
                st_next.rdata[ccn_pkg::NUM_GLB-1:0] = st_reg.glb_gate;
            end else if (int'(idx) == ccn_pkg::STAT_RGN) begin
                st_next.rdata[ccn_pkg::NUM_RGN-1:0] = st_reg.rgn_gate;
                st_next.rdata[ccn_pkg::NUM_RGN +: ccn_pkg::NUM_PPO] =
                    st_reg.ppo_gate;
            end
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_reg <= ccn_pkg::STATE_RST;
        end else begin
            st_reg <= st_next;
        end
    end

    //==========================================================================
    // outputs
    assign avm_waitrequest_o = (avm_req_i.read | avm_req_i.write) & ~st_reg.ack;
    assign avm_readdata_o = st_reg.rdata;
    assign global_clock_net_o = st_reg.glb_net;
    assign regional_clock_net_o = st_reg.rgn_net;
    assign dual_rgn_out_o = st_reg.dual_out;
    assign pll_out_pin_o = st_reg.ppo_pin;
    assign row_clock_o = st_reg.row;
    assign logic_cluster_clock_o = st_reg.clu;
    assign io_element_clock_o = st_reg.ioc;

    //==========================================================================
    // checks
    assign clu_pick0 =
        st_reg.row[st_reg.cfg[ccn_pkg::CFG_CLU][ccn_pkg::CSEL_W-1:0]];

    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (!rst_n_i);

    property p_disabled_quiet;
        ((global_clock_net_o & ~$past(st_reg.glb_gate)) == '0) &&
        ((regional_clock_net_o & ~$past(st_reg.rgn_gate)) == '0);
    endproperty
    a_disabled_quiet: assert property (p_disabled_quiet)
        else $error("disabled net produced a clock high");

    property p_gate_low_phase;
        $changed(st_reg.glb_gate[0]) |-> !$past(glb_src[0]);
    endproperty
    a_gate_low_phase: assert property (p_gate_low_phase)
        else $error("gate changed while source high");

    property p_static_off;
        (!st_reg.cfg[ccn_pkg::CFG_RGN][ccn_pkg::F_EN] && !rgn_src[0])
            |=> !st_reg.rgn_gate[0] ##1 !regional_clock_net_o[0];
    endproperty
    a_static_off: assert property (p_static_off)
        else $error("statically disabled net still enabled");

    property p_dyn_select;
        (st_reg.cfg[ccn_pkg::CFG_GLB][ccn_pkg::F_DYN] &&
         clock_source_select_i[1:0] == 2'h1)
            |-> glb_choice[0] == ccn_pkg::SRC_PIN_ODD;
    endproperty
    a_dyn_select: assert property (p_dyn_select)
        else $error("dynamic select not followed");

    property p_static_select;
        !st_reg.cfg[ccn_pkg::CFG_GLB][ccn_pkg::F_DYN]
            |-> glb_choice[0] ==
                st_reg.cfg[ccn_pkg::CFG_GLB][ccn_pkg::F_SEL +: ccn_pkg::SEL_W];
    endproperty
    a_static_select: assert property (p_static_select)
        else $error("static select not followed");

    property p_rgn_static;
        $changed(clock_source_select_i) |-> rgn_choice[0] ==
            st_reg.cfg[ccn_pkg::CFG_RGN][ccn_pkg::F_SEL +: ccn_pkg::SEL_W];
    endproperty
    a_rgn_static: assert property (p_rgn_static)
        else $error("regional source moved with dynamic select");

    property p_corner_block;
        (st_reg.cfg[ccn_pkg::CFG_GLB][ccn_pkg::F_DYN] &&
         clock_source_select_i[1] && CORNER_PLL_MASK[0])
            |-> glb_choice[0] ==
                st_reg.cfg[ccn_pkg::CFG_GLB][ccn_pkg::F_SEL +: ccn_pkg::SEL_W];
    endproperty
    a_corner_block: assert property (p_corner_block)
        else $error("corner pll dynamically selected");

    property p_even_pin;
        (glb_choice[0] == ccn_pkg::SRC_PIN_EVEN)
            |-> glb_src[0] == st_reg.pin_s2[0];
    endproperty
    a_even_pin: assert property (p_even_pin)
        else $error("even pin not on input zero");

    property p_pin_mux;
        !st_reg.cfg[ccn_pkg::CFG_PPO][ccn_pkg::F_AUX]
            |=> pll_out_pin_o[0] == $past(ppo_pin_data_i[0]);
    endproperty
    a_pin_mux: assert property (p_pin_mux)
        else $error("pll pin did not carry internal signal");

    property p_cluster_pick;
        (int'(st_reg.cfg[ccn_pkg::CFG_CLU][ccn_pkg::CSEL_W-1:0]) <
         ccn_pkg::NUM_ROW) |=> logic_cluster_clock_o[0] == $past(clu_pick0);
    endproperty
    a_cluster_pick: assert property (p_cluster_pick)
        else $error("cluster clock not the chosen row clock");
endmodule : ccn_clock_network_control

/* File: src/ccn_pkg.sv */
// package: sizes, register map, field layout and state of clock network control
//==============================================================================
package ccn_pkg;
    //==========================================================================
    // sizes
    localparam int NUM_GLB = 16;
    localparam int NUM_RGN = 8;
    localparam int NUM_PPO = 2;
    localparam int NUM_PLL = 2;
    localparam int NUM_PIN = 16;
    localparam int PIN_PAIRS = 8;
    localparam int NUM_SRC = 6;
    localparam int NUM_LINE = 24;
    localparam int NUM_ROW = 6;
    localparam int NUM_CLU = 3;
    localparam int NUM_IOC = 8;
    localparam int CFG_W = 8;
    localparam int SEL_W = 3;
    localparam int DSEL_W = 2;
    localparam int LSEL_W = 5;
    localparam int CSEL_W = 3;
    localparam int DATA_W = 32;
    localparam int ADDR_W = 10;
    localparam int ADDR_LSB = 2;
    localparam int IDX_W = ADDR_W - ADDR_LSB;
    //==========================================================================
    // source codes of a control unit selector
    localparam logic [SEL_W-1:0] SRC_PIN_EVEN = 3'h0;
    localparam logic [SEL_W-1:0] SRC_PIN_ODD = 3'h1;
    localparam logic [SEL_W-1:0] SRC_PLL_C0 = 3'h2;
    localparam logic [SEL_W-1:0] SRC_PLL_C1 = 3'h3;
    localparam logic [SEL_W-1:0] SRC_FABRIC = 3'h4;
    localparam logic [SEL_W-1:0] SRC_NEIGH = 3'h5;
    //==========================================================================
    // unit configuration fields
    localparam int F_SEL = 0;
    localparam int F_DYN = 3;
    localparam int F_EN = 4;
    localparam int F_AUX = 5;
    //==========================================================================
    // register word indices, byte address is four times the index
    localparam int CFG_GLB = 0;
    localparam int CFG_RGN = 16;
    localparam int CFG_PPO = 24;
    localparam int CFG_ROW = 26;
    localparam int CFG_CLU = 32;
    localparam int CFG_IOC = 35;
    localparam int NUM_CFG = 43;
    localparam int STAT_GLB = 64;
    localparam int STAT_RGN = 65;
    //==========================================================================
    // carriers
    typedef struct packed {
        logic read;
        logic write;
        logic [ADDR_W-1:0] address;
        logic [3:0] byteenable;
        logic [DATA_W-1:0] writedata;
    } ccn_avm_req_s;

    typedef struct packed {
        logic [NUM_PIN-1:0] pin_s1;
        logic [NUM_PIN-1:0] pin_s2;
        logic [NUM_PLL-1:0] c0_s1;
        logic [NUM_PLL-1:0] c0_s2;
        logic [NUM_PLL-1:0] c1_s1;
        logic [NUM_PLL-1:0] c1_s2;
        logic [NUM_RGN-1:0] nb_s1;
        logic [NUM_RGN-1:0] nb_s2;
        logic [NUM_CFG-1:0][CFG_W-1:0] cfg;
        logic [NUM_GLB-1:0] glb_gate;
        logic [NUM_RGN-1:0] rgn_gate;
        logic [NUM_PPO-1:0] ppo_gate;
        logic [NUM_GLB-1:0] glb_net;
        logic [NUM_RGN-1:0] rgn_net;
        logic [NUM_RGN-1:0] dual_out;
        logic [NUM_PPO-1:0] ppo_pin;
        logic [NUM_ROW-1:0] row;
        logic [NUM_CLU-1:0] clu;
        logic [NUM_IOC-1:0] ioc;
        logic ack;
        logic [DATA_W-1:0] rdata;
    } ccn_state_s;

    localparam ccn_state_s STATE_RST = '0;
endpackage : ccn_pkg

/* File: testbench/ccn_fabric_model.sv */
// partner model: fabric logic that drives clock select and enable inputs
`timescale 1ns/10ps
module ccn_fabric_model (
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    // control levels wanted by the scenario
    input wire logic [2*ccn_pkg::NUM_GLB-1:0] want_select_i,
    input wire logic [ccn_pkg::NUM_GLB-1:0] want_glb_en_i,
    input wire logic [ccn_pkg::NUM_RGN-1:0] want_rgn_en_i,
    input wire logic [ccn_pkg::NUM_PPO-1:0] want_ppo_en_i,
    // controls toward the block
    output logic [2*ccn_pkg::NUM_GLB-1:0] clock_source_select_o,
    output logic [ccn_pkg::NUM_GLB-1:0] glb_enable_o,
    output logic [ccn_pkg::NUM_RGN-1:0] rgn_enable_o,
    output logic [ccn_pkg::NUM_PPO-1:0] ppo_enable_o
);
    //==========================================================================
    // one register stage keeps the controls free of runt pulses
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            clock_source_select_o <= '0;
            glb_enable_o <= '0;
            rgn_enable_o <= '0;
            ppo_enable_o <= '0;
        end else begin
            clock_source_select_o <= want_select_i;
            glb_enable_o <= want_glb_en_i;
            rgn_enable_o <= want_rgn_en_i;
            ppo_enable_o <= want_ppo_en_i;
        end
    end
endmodule : ccn_fabric_model

/* File: testbench/ccn_clock_network_control_tb.sv */
// testbench: register setup, source selection, gating and clock buses
`timescale 1ns/10ps
module ccn_clock_network_control_tb;
    //==========================================================================
    // signals
    logic clk_sys_i = 1'b0;
    logic rst_n_i = 1'b0;
    ccn_pkg::ccn_avm_req_s avm_req = '{1'b0, 1'b0, 10'h000, 4'hf, 32'h0000_0000};
    logic [31:0] avm_readdata;
    logic avm_waitrequest;
    logic [7:0] src_cnt = 8'h00;
    logic [31:0] want_sel = 32'h0000_0000;
    logic [15:0] want_glb = 16'h0000;
    logic [7:0] want_rgn = 8'h00;
    logic [1:0] want_ppo = 2'h0;
    logic [31:0] sel;
    logic [15:0] glb_en, glb_net;
    logic [7:0] rgn_en, rgn_net, dual_out, ioc;
    logic [1:0] ppo_en, ppo_pin;
    logic [5:0] row;
    logic [2:0] clu;
    int n_fail = 0;
    int checks_done = 0;
    int cyc = 0;
    always #12.5 clk_sys_i = ~clk_sys_i;
    always @(posedge clk_sys_i) src_cnt <= src_cnt + 8'h01;
    //==========================================================================
    // instances
    ccn_clock_network_control #(
        .CORNER_PLL_MASK(2'h1)
    ) i_ccn_clock_network_control (
        .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .avm_req_i(avm_req),
        .avm_readdata_o(avm_readdata), .avm_waitrequest_o(avm_waitrequest),
        .clk_pin_i({8{src_cnt[2], src_cnt[1]}}),
        .pll_counter_output_zero_i({2{src_cnt[3]}}),
        .pll_counter_output_one_i({2{src_cnt[4]}}),
        .glb_fabric_src_i({16{src_cnt[5]}}), .rgn_fabric_src_i({8{src_cnt[5]}}),
        .ppo_fabric_src_i({2{src_cnt[5]}}), .dual_rgn_neigh_i({8{src_cnt[0]}}),
        .clock_source_select_i(sel), .glb_enable_i(glb_en),
        .rgn_enable_i(rgn_en), .ppo_enable_i(ppo_en),
        .ppo_pin_data_i({2{src_cnt[6]}}), .global_clock_net_o(glb_net),
        .regional_clock_net_o(rgn_net), .dual_rgn_out_o(dual_out),
        .pll_out_pin_o(ppo_pin), .row_clock_o(row),
        .logic_cluster_clock_o(clu), .io_element_clock_o(ioc));
    ccn_fabric_model i_ccn_fabric_model (
        .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .want_select_i(want_sel),
        .want_glb_en_i(want_glb), .want_rgn_en_i(want_rgn),
        .want_ppo_en_i(want_ppo), .clock_source_select_o(sel),
        .glb_enable_o(glb_en), .rgn_enable_o(rgn_en), .ppo_enable_o(ppo_en));
    //==========================================================================
    // shared tasks
    task automatic summarize();
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : summarize
    always @(posedge clk_sys_i) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_fail++;
            summarize();
        end
    end
    task automatic check(input string what, input logic [31:0] exp,
                         input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected %s: expected %0h seen %0h", what, exp, got);
        end
    endtask : check
    task automatic bus(input logic wr, input int idx, input logic [7:0] wd,
                       output logic [31:0] rd);
        int k;
        k = 0;
        avm_req.read <= !wr;
        avm_req.write <= wr;
        avm_req.address <= 10'(idx * 4);
        avm_req.writedata <= {24'h00_0000, wd};
        do begin
            @(posedge clk_sys_i);
            k++;
        end while (avm_waitrequest !== 1'b0 && k < 50);
        rd = avm_readdata;
        avm_req.read <= 1'b0;
        avm_req.write <= 1'b0;
        if (k >= 50) check("bus answer", 32'h0000_0000, 32'h0000_0001);
        @(posedge clk_sys_i);
    endtask : bus
    task automatic wr(input int idx, input logic [7:0] wd);
        logic [31:0] rd;
        bus(1'b1, idx, wd, rd);
    endtask : wr
    task automatic rd_check(input int idx, input logic [31:0] exp);
        logic [31:0] rd;
        bus(1'b0, idx, 8'h00, rd);
        check($sformatf("register %0d", idx), exp, rd);
    endtask : rd_check
    function automatic logic pick(input int kind, input int idx);
        case (kind)
            0: pick = glb_net[idx];
            1: pick = rgn_net[idx];
            2: pick = dual_out[idx];
            3: pick = ppo_pin[idx];
            4: pick = row[idx];
            5: pick = clu[idx];
            default: pick = ioc[idx];
        endcase
    endfunction : pick
    // rising edges in 128 cycles; source counter bit b gives 128>>(b+1)
    task automatic edges(input int kind, input int idx, input int b);
        logic prv, cur;
        int n;
        n = 0;
        repeat (8) @(posedge clk_sys_i);
        #1;
        prv = pick(kind, idx);
        repeat (128) begin
            @(posedge clk_sys_i);
            #1;
            cur = pick(kind, idx);
            if (cur === 1'b1 && prv === 1'b0) n++;
            prv = cur;
        end
        @(posedge clk_sys_i);
        check($sformatf("edges kind %0d unit %0d", kind, idx),
              32'(128 >> (b + 1)), n);
    endtask : edges
    //==========================================================================
    // scenarios
    task automatic t_reset_state();
        rd_check(0, 32'h0000_0000);
        rd_check(16, 32'h0000_0000);
        edges(0, 0, 7);
        wr(50, 8'hff);
        rd_check(50, 32'h0000_0000);
        wr(64, 8'hff);
        rd_check(64, 32'h0000_0000);
    endtask : t_reset_state
    task automatic t_static_select();
        want_glb[0] <= 1'b1;
        for (int c = 0; c < 5; c++) begin
            wr(0, 8'h10 | 8'(c));
            rd_check(0, 32'h0000_0010 | 32'(c));
            edges(0, 0, c + 1);
        end
        wr(0, 8'h16);
        edges(0, 0, 7);
    endtask : t_static_select
    task automatic t_dynamic_select();
        want_glb[1] <= 1'b1;
        wr(1, 8'h18);
        for (int c = 0; c < 4; c++) begin
            want_sel[3:2] <= 2'(c);
            edges(0, 1, c + 1);
        end
        want_sel[1:0] <= 2'h2;
        wr(0, 8'h19);
        edges(0, 0, 2);
        want_sel[1:0] <= 2'h0;
    endtask : t_dynamic_select
    task automatic t_enable_gate();
        int run;
        logic armed;
        wr(0, 8'h10);
        want_glb[0] <= 1'b0;
        edges(0, 0, 7);
        want_glb[0] <= 1'b1;
        edges(0, 0, 1);
        rd_check(64, 32'h0000_0003);
        wr(0, 8'h00);
        edges(0, 0, 7);
        wr(0, 8'h10);
        run = 0;
        armed = 1'b0;
        for (int i = 0; i < 200; i++) begin
            @(posedge clk_sys_i);
            if (i % 7 == 0) want_glb[0] <= ~want_glb[0];
            #1;
            if (glb_net[0] === 1'b1) begin
                if (armed) run++;
            end else begin
                if (run != 0) begin
                    check("high pulse length", 2, run);
                end
                run = 0;
                armed = 1'b1;
            end
        end
        @(posedge clk_sys_i);
        want_glb[0] <= 1'b1;
    endtask : t_enable_gate
    task automatic t_regional();
        want_rgn <= 8'h07;
        wr(16, 8'h31);
        edges(1, 0, 2);
        edges(2, 0, 2);
        wr(17, 8'h15);
        edges(1, 1, 0);
        want_sel <= 32'hffff_ffff;
        wr(18, 8'h18);
        edges(1, 2, 1);
        want_sel <= 32'h0000_0000;
    endtask : t_regional
    task automatic t_pll_pin();
        want_ppo[0] <= 1'b1;
        wr(24, 8'h22);
        edges(3, 0, 3);
        wr(24, 8'h02);
        edges(3, 0, 6);
        wr(24, 8'h22);
        want_ppo[0] <= 1'b0;
        edges(3, 0, 7);
    endtask : t_pll_pin
    task automatic t_buses();
        wr(26, 8'h00);
        edges(4, 0, 1);
        wr(27, 8'h11);
        edges(4, 1, 0);
        wr(32, 8'h01);
        edges(5, 0, 0);
        wr(35, 8'h10);
        edges(6, 0, 2);
    endtask : t_buses
    //==========================================================================
    // main sequence
    initial begin
        repeat (2) @(posedge clk_sys_i);
        rst_n_i <= 1'b1;
        @(posedge clk_sys_i);
        t_reset_state();
        t_static_select();
        t_dynamic_select();
        t_enable_gate();
        t_regional();
        t_pll_pin();
        t_buses();
        summarize();
    end
endmodule : ccn_clock_network_control_tb
